/* design/rf_route_regs.svh */
// register map, field positions and reset values of the rf signal routing block
`ifndef RF_ROUTE_REGS_SVH
`define RF_ROUTE_REGS_SVH

// byte addresses
`define ADDR_RECEIVER_CONFIG  8'h38
`define ADDR_AUX_OUT_CONFIG   8'h3C
`define ADDR_DRIVER_CONTROL   8'h40
`define ADDR_RECEIVE_CONTROL  8'h44
`define ADDR_ROUTE_STATUS     8'h48

// receiver_config fields
`define RCV_SINGLE_BIT        0
`define RCV_ADC_BIT           1
`define RCV_SEL_LSB           2
`define RCV_SEL_MSB           3
`define RCV_RESET             8'h04

// aux_out_config fields
`define AUX_SEL_LSB           0
`define AUX_SEL_MSB           3
`define AUX_RESET             8'h00

// driver_control fields
`define DRV_SEL_LSB           0
`define DRV_SEL_MSB           1
`define DRV_RESET             8'h01

// receive_control fields
`define RXC_MULTI_BIT         0
`define RXC_RESET             8'h00

// receive input source codes
`define RX_SRC_NONE           2'h0
`define RX_SRC_INTERNAL       2'h1
`define RX_SRC_AUX_TYPE_A     2'h2
`define RX_SRC_AUX_GENERIC    2'h3

// driver source codes
`define DRV_SRC_IDLE          2'h0
`define DRV_SRC_INTERNAL      2'h1
`define DRV_SRC_AUX_IN        2'h2
`define DRV_SRC_RESERVED      2'h3

// aux output source codes
`define AUX_SRC_LOW           4'h0
`define AUX_SRC_RX_INTERNAL   4'h1
`define AUX_SRC_AUX_IN        4'h2
`define AUX_SRC_DRIVER        4'h3
`define AUX_SRC_ENVELOPE      4'h4
`define AUX_SRC_MANCH_GENERIC 4'h6
`define AUX_SRC_MANCH_SUBC    4'h7

// route_status bits
`define STS_AUX_IN_BIT        0
`define STS_RX_DATA_BIT       1
`define STS_AUX_OUT_BIT       2
`define STS_RESERVED_BIT      3
`define STS_OVERLAP_BIT       4

`endif

/* design/rf_route_pkg.sv */
// types shared by the rf signal routing block
package rf_route_pkg;

	// coder outputs of the digital core
	typedef struct packed {
		logic envelope;
		logic manchester_generic;
		logic manchester_subcarrier;
	} core_tx_t;

	// receive data handed to the decoder core
	typedef struct packed {
		logic data;
		logic type_a;
		logic valid;
	} core_rx_t;

	// analog front end controls
	typedef struct packed {
		logic rx_single_ended;
		logic mixer_direct_adc;
		logic multi_frame_receive;
	} analog_cfg_t;

endpackage

/* design/sync_pin.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sync_pin #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// asynchronous input and filtered output
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;

	// capture chain, first stage seen only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff   <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end else begin
			meta_ff   <= async_in;
			stage2_ff <= meta_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// take a bit once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2_ff[i] == stage3_ff[i]) begin
					sync_out[i] <= stage3_ff[i];
				end
			end
		end
	end

endmodule

/* design/rf_frontend_signal_routing.sv */
// routing between coder core, analog front end and the aux pins, with apb registers
// Function
// - receiver mode bit: differential or single-ended
// - mixer-direct-adc bit couples mixers to adc
// - digital side: envelope out, drivers idle, aux receive
// - receive source: internal, aux type a, aux generic
// - aux out 0110 generic, 0111 subcarrier manchester
// - antenna side: internal rx, drive from aux, multiframe
// - aux out value 4 carries envelope coder
// - receive select 1 conflict resolved as internal
// - passive and active paths coexist, used sequentially
// - aux out doubles as test observation mux
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "rf_route_regs.svh"
module rf_frontend_signal_routing
	import rf_route_pkg::*;
(
	// apb clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// digital core side
	input  wire core_tx_t    core_tx,
	output      core_rx_t    core_rx,
	// analog receiver data, asynchronous to pclk
	input  wire logic        analog_rx_data,
	// analog front end configuration
	output      analog_cfg_t analog_cfg,
	// antenna driver pins
	output      logic        antenna_driver_a,
	output      logic        antenna_driver_b,
	// auxiliary pins
	input  wire logic        aux_input_pin,
	output      logic        aux_output_pin
);

	logic [7:0] receiver_config_ff;
	logic [7:0] aux_out_config_ff;
	logic [7:0] driver_control_ff;
	logic [7:0] receive_control_ff;
	logic [31:0] prdata_ff;
	logic       pslverr_ff;
	logic       aux_in_sync;
	logic       rx_int_sync;
	logic [1:0] rx_sel;
	logic [3:0] aux_sel;
	logic [1:0] drv_sel;
	logic       setup_phase;
	logic       wr_access;
	logic       addr_hit;
	logic       aux_reserved;
	logic       drv_reserved;
	logic       path_overlap;
	logic [31:0] nxt_prdata;
	logic       nxt_aux_out;
	logic       nxt_driver;
	logic       nxt_rx_data;

	// external aux pin and analog data cross into pclk
	sync_pin #(
		.WIDTH (2)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({analog_rx_data, aux_input_pin}),
		.sync_out ({rx_int_sync, aux_in_sync})
	);

	// field extraction
	assign rx_sel  = receiver_config_ff[`RCV_SEL_MSB:`RCV_SEL_LSB];
	assign aux_sel = aux_out_config_ff[`AUX_SEL_MSB:`AUX_SEL_LSB];
	assign drv_sel = driver_control_ff[`DRV_SEL_MSB:`DRV_SEL_LSB];

	// apb phase decode
	assign setup_phase = psel && !penable;
	assign wr_access   = psel && penable && pwrite && !pslverr_ff;
	assign addr_hit    = (paddr == `ADDR_RECEIVER_CONFIG) || (paddr == `ADDR_AUX_OUT_CONFIG) ||
	                     (paddr == `ADDR_DRIVER_CONTROL) || (paddr == `ADDR_RECEIVE_CONTROL) ||
	                     (paddr == `ADDR_ROUTE_STATUS);

	// zero wait state slave
	assign pready  = 1'b1;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff && psel && penable;

	// register writes, low byte lane only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receiver_config_ff <= `RCV_RESET;
			aux_out_config_ff  <= `AUX_RESET;
			driver_control_ff  <= `DRV_RESET;
			receive_control_ff <= `RXC_RESET;
		end else if (wr_access && pstrb[0]) begin
			unique case (paddr)
				`ADDR_RECEIVER_CONFIG: begin
					receiver_config_ff <= {4'h0, pwdata[3:0]};
				end
				`ADDR_AUX_OUT_CONFIG: begin
					aux_out_config_ff <= {4'h0, pwdata[3:0]};
				end
				`ADDR_DRIVER_CONTROL: begin
					driver_control_ff <= {6'h00, pwdata[1:0]};
				end
				`ADDR_RECEIVE_CONTROL: begin
					receive_control_ff <= {7'h00, pwdata[0]};
				end
				default: begin
				end
			endcase
		end
	end

	// read data mux
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			`ADDR_RECEIVER_CONFIG: nxt_prdata = {24'h00_0000, receiver_config_ff};
			`ADDR_AUX_OUT_CONFIG:  nxt_prdata = {24'h00_0000, aux_out_config_ff};
			`ADDR_DRIVER_CONTROL:  nxt_prdata = {24'h00_0000, driver_control_ff};
			`ADDR_RECEIVE_CONTROL: nxt_prdata = {24'h00_0000, receive_control_ff};
			`ADDR_ROUTE_STATUS: begin
				nxt_prdata[`STS_AUX_IN_BIT]   = aux_in_sync;
				nxt_prdata[`STS_RX_DATA_BIT]  = core_rx.data;
				nxt_prdata[`STS_AUX_OUT_BIT]  = aux_output_pin;
				nxt_prdata[`STS_RESERVED_BIT] = aux_reserved || drv_reserved;
				nxt_prdata[`STS_OVERLAP_BIT]  = path_overlap;
			end
			default: nxt_prdata = 32'h0000_0000;
		endcase
	end

	// read data and error latched in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup_phase) begin
			prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
			pslverr_ff <= !addr_hit || (pwrite && (paddr == `ADDR_ROUTE_STATUS));
		end
	end

	// analog front end controls
	// single-ended select
	assign analog_cfg.rx_single_ended = receiver_config_ff[`RCV_SINGLE_BIT];
	assign analog_cfg.mixer_direct_adc = receiver_config_ff[`RCV_ADC_BIT];
	assign analog_cfg.multi_frame_receive = receive_control_ff[`RXC_MULTI_BIT];

	// reserved code detection
	// undocumented codes flagged
	assign aux_reserved = !(aux_sel inside {`AUX_SRC_LOW, `AUX_SRC_RX_INTERNAL,
	                        `AUX_SRC_AUX_IN, `AUX_SRC_DRIVER, `AUX_SRC_ENVELOPE,
	                        `AUX_SRC_MANCH_GENERIC, `AUX_SRC_MANCH_SUBC});
	assign drv_reserved = (drv_sel == `DRV_SRC_RESERVED);

	// both rf paths armed at once
	assign path_overlap = (drv_sel == `DRV_SRC_INTERNAL) &&
	                      (aux_sel == `AUX_SRC_ENVELOPE);

	// aux output source mux
	always_comb begin
		nxt_aux_out = 1'b0;
		unique case (aux_sel)
			`AUX_SRC_RX_INTERNAL:   nxt_aux_out = rx_int_sync;
			`AUX_SRC_AUX_IN:        nxt_aux_out = aux_in_sync;
			`AUX_SRC_DRIVER:        nxt_aux_out = antenna_driver_a;
			`AUX_SRC_ENVELOPE:      nxt_aux_out = core_tx.envelope;
			`AUX_SRC_MANCH_GENERIC: nxt_aux_out = core_tx.manchester_generic;
			`AUX_SRC_MANCH_SUBC:    nxt_aux_out = core_tx.manchester_subcarrier;
			default:                nxt_aux_out = 1'b0;
		endcase
	end

	// antenna driver source mux
	always_comb begin
		nxt_driver = 1'b0;
		unique case (drv_sel)
			`DRV_SRC_IDLE:     nxt_driver = 1'b0;
			`DRV_SRC_INTERNAL: nxt_driver = core_tx.envelope;
			`DRV_SRC_AUX_IN:   nxt_driver = aux_in_sync;
			default:           nxt_driver = 1'b0;
		endcase
	end

	// receive input source mux
	always_comb begin
		nxt_rx_data = 1'b0;
		unique case (rx_sel)
			`RX_SRC_INTERNAL:    nxt_rx_data = rx_int_sync;
			`RX_SRC_AUX_TYPE_A:  nxt_rx_data = aux_in_sync;
			`RX_SRC_AUX_GENERIC: nxt_rx_data = aux_in_sync;
			default:             nxt_rx_data = 1'b0;
		endcase
	end

	// registered pin and core outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_output_pin   <= 1'b0;
			antenna_driver_a <= 1'b0;
			antenna_driver_b <= 1'b0;
			core_rx          <= '0;
		end else begin
			aux_output_pin   <= nxt_aux_out;
			antenna_driver_a <= nxt_driver;
			antenna_driver_b <= nxt_driver;
			core_rx.data     <= nxt_rx_data;
			core_rx.type_a   <= (rx_sel == `RX_SRC_AUX_TYPE_A);
			core_rx.valid    <= (rx_sel != `RX_SRC_NONE);
		end
	end

	// checks of the routing behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RX_SINGLE: assert property (
		(wr_access && pstrb[0] && paddr == `ADDR_RECEIVER_CONFIG) |=>
		analog_cfg.rx_single_ended == $past(pwdata[`RCV_SINGLE_BIT])
	) else $error("receiver mode bit did not follow write");

	AST_ADC_DIRECT: assert property (
		(wr_access && pstrb[0] && paddr == `ADDR_RECEIVER_CONFIG) |=>
		analog_cfg.mixer_direct_adc == $past(pwdata[`RCV_ADC_BIT])
	) else $error("mixer direct adc bit did not follow write");

	AST_DRV_IDLE: assert property (
		(drv_sel == `DRV_SRC_IDLE) [*2] |-> !antenna_driver_a && !antenna_driver_b
	) else $error("drivers not low in idle");

	AST_RX_AUX: assert property (
		(rx_sel == `RX_SRC_AUX_TYPE_A || rx_sel == `RX_SRC_AUX_GENERIC) |=>
		core_rx.data == $past(aux_in_sync) && core_rx.valid
	) else $error("receive data not taken from aux input");

	AST_MANCH_OUT: assert property (
		(aux_sel == `AUX_SRC_MANCH_SUBC) |=>
		aux_output_pin == $past(core_tx.manchester_subcarrier)
	) else $error("subcarrier manchester not on aux output");

	AST_DRV_AUX: assert property (
		(drv_sel == `DRV_SRC_AUX_IN) |=> antenna_driver_a == $past(aux_in_sync) &&
		antenna_driver_b == $past(aux_in_sync)
	) else $error("drivers not following aux input");

	AST_ENV_OUT: assert property (
		(aux_sel == `AUX_SRC_ENVELOPE) |=> aux_output_pin == $past(core_tx.envelope)
	) else $error("envelope not on aux output");

	AST_RX_INTERNAL: assert property (
		(rx_sel == `RX_SRC_INTERNAL) |=> core_rx.data == $past(rx_int_sync) && !core_rx.type_a
	) else $error("select one not routed to internal receiver");

	AST_TEST_TAP: assert property (
		(aux_sel == `AUX_SRC_RX_INTERNAL) |=> aux_output_pin == $past(rx_int_sync)
	) else $error("test tap not on aux output");

	AST_RESERVED_LOW: assert property (
		aux_reserved |=> !aux_output_pin
	) else $error("reserved aux code did not force low");

	AST_APB_ERR: assert property (
		(setup_phase && !addr_hit) |=> pslverr
	) else $error("unmapped access not flagged");

	AST_GENERIC_OUT: assert property (
		(aux_sel == `AUX_SRC_MANCH_GENERIC) |=>
		aux_output_pin == $past(core_tx.manchester_generic)
	) else $error("generic manchester not on aux output");

	AST_RX_TYPE_A: assert property (
		(rx_sel == `RX_SRC_AUX_TYPE_A) |=> core_rx.type_a && core_rx.valid
	) else $error("type a receive not flagged");

	AST_RX_NONE: assert property (
		(rx_sel == `RX_SRC_NONE) |=> !core_rx.valid && !core_rx.data
	) else $error("receive data valid with no source selected");

	AST_MULTI_FRAME: assert property (
		(wr_access && pstrb[0] && paddr == `ADDR_RECEIVE_CONTROL) |=>
		analog_cfg.multi_frame_receive == $past(pwdata[`RXC_MULTI_BIT])
	) else $error("multiple frame bit did not follow write");

	AST_DRV_PASSIVE: assert property (
		(drv_sel == `DRV_SRC_INTERNAL) |=> antenna_driver_a == $past(core_tx.envelope)
	) else $error("passive antenna drivers not following envelope");

	AST_DRV_RESERVED: assert property (
		drv_reserved |=> !antenna_driver_a && !antenna_driver_b
	) else $error("reserved driver code did not force low");

	AST_TEST_DRIVER: assert property (
		(aux_sel == `AUX_SRC_DRIVER) |=> aux_output_pin == $past(antenna_driver_a)
	) else $error("driver tap not on aux output");

	AST_TEST_AUX_IN: assert property (
		(aux_sel == `AUX_SRC_AUX_IN) |=> aux_output_pin == $past(aux_in_sync)
	) else $error("aux input tap not on aux output");

	AST_AUX_LOW: assert property (
		(aux_sel == `AUX_SRC_LOW) |=> !aux_output_pin
	) else $error("aux output not low on code zero");

	AST_REFUSED_DATA: assert property (
		(setup_phase && (!addr_hit || pwrite)) |=>
		prdata == 32'h0000_0000
	) else $error("refused or write access returned data");

	// main scenarios
	CVR_DIGITAL_SIDE: cover property (
		aux_sel == `AUX_SRC_ENVELOPE && drv_sel == `DRV_SRC_IDLE &&
		rx_sel == `RX_SRC_AUX_TYPE_A
	);
	CVR_ANTENNA_SIDE: cover property (
		aux_sel == `AUX_SRC_MANCH_SUBC && drv_sel == `DRV_SRC_AUX_IN &&
		rx_sel == `RX_SRC_INTERNAL && analog_cfg.multi_frame_receive
	);
	CVR_OVERLAP: cover property (path_overlap);
	CVR_SINGLE_ADC: cover property (analog_cfg.rx_single_ended && analog_cfg.mixer_direct_adc);
	CVR_RESERVED: cover property (aux_reserved && drv_reserved);

endmodule

/* dv/rf_active_antenna.sv */
// behavioural active antenna answering the reader on its aux pins
`timescale 1ns/1ps
module rf_active_antenna (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// reply level and answer speed from the bench
	input  wire logic reply_level,
	input  wire logic slow,
	// aux input pin of the reader
	output      logic aux_input_pin
);
	logic stage_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_ff      <= 1'h0;
			aux_input_pin <= 1'h0;
		end else begin
			stage_ff      <= reply_level;
			aux_input_pin <= slow ? stage_ff : reply_level; // slow adds a cycle
		end
	end
endmodule

/* dv/tb_top.sv */
// self-checking bench of the rf signal routing block
`timescale 1ns/1ps
`include "rf_route_regs.svh"
module tb_top
	import rf_route_pkg::*;
;
	localparam logic [7:0]  REG_ADDR [4] = '{`ADDR_RECEIVER_CONFIG, `ADDR_AUX_OUT_CONFIG,
		`ADDR_DRIVER_CONTROL, `ADDR_RECEIVE_CONTROL};
	localparam logic [31:0] REG_RST  [4] = '{32'h04, 32'h00, 32'h01, 32'h00};
	localparam logic [31:0] REG_MASK [4] = '{32'h0F, 32'h0F, 32'h03, 32'h01};
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	core_tx_t    core_tx;
	core_rx_t    core_rx;
	logic        analog_rx_data;
	analog_cfg_t analog_cfg;
	logic        antenna_driver_a;
	logic        antenna_driver_b;
	logic        aux_input_pin;
	logic        aux_output_pin;
	logic        reply_level;
	logic        slow;
	int          err_total;
	int          checked;
	int          cycles;
	logic [31:0] rd;
	logic        er;
	logic [4:0]  src;
	logic        ex;

	rf_frontend_signal_routing i_rf_frontend_signal_routing (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_tx(core_tx), .core_rx(core_rx),
		.analog_rx_data(analog_rx_data), .analog_cfg(analog_cfg),
		.antenna_driver_a(antenna_driver_a), .antenna_driver_b(antenna_driver_b),
		.aux_input_pin(aux_input_pin), .aux_output_pin(aux_output_pin));

	rf_active_antenna i_rf_active_antenna (
		.pclk(pclk), .presetn(presetn), .reply_level(reply_level), .slow(slow),
		.aux_input_pin(aux_input_pin));

	// free running clock
	always #5 pclk = ~pclk;

	// cuts a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	// one apb transfer, released at the edge that sees pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic [3:0] st);
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		pstrb   <= st;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	// compares and counts
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// counts and verdict
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// applies source levels and lets the synchronisers settle
	task automatic drive(input logic [4:0] s);
		@(posedge pclk);
		core_tx        <= core_tx_t'({s[0], s[1], s[2]});
		reply_level    <= s[3];
		analog_rx_data <= s[4];
		repeat (10) @(posedge pclk);
	endtask

	// expected driver level: s is env, generic, subcarrier, aux in, analog rx
	function automatic logic exp_drv(input logic [1:0] d, input logic [4:0] s);
		case (d)
			2'h1:    return s[0];
			2'h2:    return s[3];
			default: return 1'h0;
		endcase
	endfunction

	// expected aux output level
	function automatic logic exp_aux(input logic [3:0] c, input logic [1:0] d,
		input logic [4:0] s);
		case (c)
			4'h1:    return s[4];
			4'h2:    return s[3];
			4'h3:    return exp_drv(d, s);
			4'h4:    return s[0];
			4'h6:    return s[1];
			4'h7:    return s[2];
			default: return 1'h0;
		endcase
	endfunction

	// main sequence
	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		core_tx = core_tx_t'(3'h0);
		analog_rx_data = 1'h0;
		reply_level = 1'h0;
		slow = 1'h0;
		err_total = 0;
		checked = 0;
		cycles = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		// reset values, byte strobe, read-only upper bits
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, REG_ADDR[i], 32'h0, 4'h0);
			check("reset value", rd, REG_RST[i]);
			apb(1'h1, REG_ADDR[i], 32'hFFFFFFFF, 4'hE);
			apb(1'h0, REG_ADDR[i], 32'h0, 4'h0);
			check("strobe ignored", rd, REG_RST[i]);
			apb(1'h1, REG_ADDR[i], 32'hFFFFFFFF, 4'hF);
			apb(1'h0, REG_ADDR[i], 32'h0, 4'h0);
			check("readback", rd, REG_MASK[i]);
			check("no error", 32'(er), 32'h0);
		end
		apb(1'h0, 8'h50, 32'h0, 4'h0);
		check("unmapped error", 32'(er), 32'h1);
		check("unmapped data", rd, 32'h0);
		apb(1'h1, `ADDR_ROUTE_STATUS, 32'hFFFFFFFF, 4'hF);
		check("status write error", 32'(er), 32'h1);
		// every driver and aux code against one-hot sources
		apb(1'h1, `ADDR_RECEIVER_CONFIG, 32'h04, 4'hF);
		for (int d = 0; d < 4; d++) begin
			slow <= d[0];
			for (int c = 0; c < 16; c++) begin
				apb(1'h1, `ADDR_DRIVER_CONTROL, 32'(d), 4'hF);
				apb(1'h1, `ADDR_AUX_OUT_CONFIG, 32'(c), 4'hF);
				for (int k = 0; k < 5; k++) begin
					src = 5'h01 << k;
					drive(src);
					ex = exp_aux(4'(c), 2'(d), src);
					check("aux out", 32'(aux_output_pin), 32'(ex));
					ex = exp_drv(2'(d), src);
					check("driver a", 32'(antenna_driver_a), 32'(ex));
					check("driver b", 32'(antenna_driver_b), 32'(ex));
				end
				apb(1'h0, `ADDR_ROUTE_STATUS, 32'h0, 4'h0);
				src = 5'({d == 1 && c == 4, d == 3 || c == 5 || c > 7});
				check("status flags", 32'(rd[4:3]), 32'(src));
				ex = exp_aux(4'(c), 2'(d), 5'h10);
				check("status levels", 32'(rd[2:0]), 32'({ex, 2'h2}));
			end
		end
		// receive source decode and analog settings
		apb(1'h1, `ADDR_RECEIVE_CONTROL, 32'h1, 4'hF);
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, `ADDR_RECEIVER_CONFIG, 32'(s * 5), 4'hF);
			for (int k = 0; k < 4; k++) begin
				drive({k[1], k[0], 3'h0});
				ex = (s == 1) ? k[1] : ((s > 1) ? k[0] : 1'h0);
				check("core rx", 32'(core_rx), 32'({ex, s == 2, s != 0}));
			end
			check("analog cfg", 32'(analog_cfg), 32'({s[0], s[1], 1'h1}));
		end
		print_verdict();
	end
endmodule
